// ===== rtl/pwmcri_consts.vh
// Purpose: constants for the pwm channel register interface
// Assumes: byte addresses on a 32-bit ahb-lite bus
// Notes: definitions only
`ifndef PWMCRI_CONSTS_VH
`define PWMCRI_CONSTS_VH

// global register byte offsets
`define PWMCRI_OFS_MODE 12'h000
`define PWMCRI_OFS_ENA 12'h004
`define PWMCRI_OFS_DIS 12'h008
`define PWMCRI_OFS_STAT 12'h00c
`define PWMCRI_OFS_IER 12'h010
`define PWMCRI_OFS_IDR 12'h014
`define PWMCRI_OFS_IMR 12'h018
`define PWMCRI_OFS_ISR 12'h01c

// channel window: base 0x200, stride 0x20
`define PWMCRI_CH_BASE_HI 3'h1
`define PWMCRI_CH_REG_MODE 3'h0
`define PWMCRI_CH_REG_DUTY 3'h1
`define PWMCRI_CH_REG_PRD 3'h2
`define PWMCRI_CH_REG_CNT 3'h3
`define PWMCRI_CH_REG_UPD 3'h4

// channel mode fields
`define PWMCRI_PSC_LSB 0
`define PWMCRI_PSC_MSB 3
`define PWMCRI_ALIGN_BIT 8
`define PWMCRI_POL_BIT 9
`define PWMCRI_TGT_BIT 10
`define PWMCRI_PSC_CLK_A 4'hb
`define PWMCRI_PSC_CLK_B 4'hc

// global mode fields: divisor a low byte, prescale a next
`define PWMCRI_DIV_A_LSB 0
`define PWMCRI_PRE_A_LSB 8
`define PWMCRI_DIV_B_LSB 16
`define PWMCRI_PRE_B_LSB 24

// widths and reset values
`define PWMCRI_CNT_W 16
`define PWMCRI_PRE_W 10
`define PWMCRI_RST_16 16'h0000
`define PWMCRI_RST_MODE 11'h000

`endif

// ===== rtl/pwmcri_top.v
// Purpose: pwm channels with an ahb-lite register interface
// Assumes: single 40 MHz clock, synchronous active-high reset
// Notes: reads take one wait state, writes none
// Overview of operation
// - interrupt disable write one clears mask
// - mask read shows enabled channel interrupts
// - status flag set by completed period
// - status read clears returned flags
// - prescale field selects counter clock source
// - alignment bit: left or center
// - polarity bit sets period start level
// - update target: duty or period
// - update register buffers written value
// - buffered value applied at period start
// - only low sixteen bits used
// - left period is period times divisor
// - center period is twice that
// - counter clears on enable, readable
// - left counter wraps at period value
// - interrupt held until status read
// - interrupt enable write one sets mask
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "pwmcri_consts.vh"

module pwmcri_top #(
    parameter N = 4
) (
    input wire i_clk, // master clock
    input wire i_rst, // sync reset, high
    input wire i_hsel, // slave select
    input wire [31:0] i_haddr, // byte address
    input wire [1:0] i_htrans, // transfer type
    input wire i_hwrite, // write when high
    input wire [2:0] i_hsize, // word only
    input wire [31:0] i_hwdata, // write data
    input wire i_hready, // bus ready in
    output wire o_hreadyout, // slave ready
    output wire o_hresp, // always okay
    output reg [31:0] o_hrdata, // read data
    output wire [N-1:0] o_pwm, // channel outputs
    output wire o_irq // period interrupt
);

    localparam CW = `PWMCRI_CNT_W;
    localparam PW = `PWMCRI_PRE_W;

    // ahb address phase capture
    reg wr_pend_r;
    reg rd_pend_r;
    reg [11:0] addr_r;
    wire take = i_hsel & i_hready & i_htrans[1];

    // a read stalls its own data phase, so no new address
    // can be taken while rd_pend_r is high
    always @(posedge i_clk) begin
        if (i_rst) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 12'h000;
        end else begin
            if (o_hreadyout) begin
                wr_pend_r <= take & i_hwrite;
                rd_pend_r <= take & ~i_hwrite;
                if (take) begin
                    addr_r <= i_haddr[11:0];
                end
            end else begin
                rd_pend_r <= 1'b0;
            end
        end
    end

    // read holds one wait state while data is latched
    assign o_hreadyout = ~rd_pend_r;
    assign o_hresp = 1'b0;

    // decode of the captured address
    wire wr = wr_pend_r;
    wire in_ch = (addr_r[11:9] == `PWMCRI_CH_BASE_HI) & ~addr_r[8];
    wire [2:0] ch_sel = addr_r[7:5];
    wire [2:0] ch_reg = addr_r[4:2];
    wire ch_ok = in_ch & ({1'b0, ch_sel} < N) & (addr_r[1:0] == 2'b00);
    // global writes compare all twelve captured bits, so the
    // channel window and the unmapped hole never alias onto them
    wire wr_ena = wr & (addr_r == `PWMCRI_OFS_ENA);
    wire wr_dis = wr & (addr_r == `PWMCRI_OFS_DIS);
    wire wr_ier = wr & (addr_r == `PWMCRI_OFS_IER);
    wire wr_idr = wr & (addr_r == `PWMCRI_OFS_IDR);
    wire wr_mr = wr & (addr_r == `PWMCRI_OFS_MODE);
    wire rd_isr = rd_pend_r & (addr_r == `PWMCRI_OFS_ISR);

    // global mode, enable, mask and status registers
    reg [31:0] mr_r;
    reg [N-1:0] ena_r;
    reg [N-1:0] imr_r;
    reg [N-1:0] isr_r;
    wire [N-1:0] period_end;
    // set wins: a period end in the status read cycle stays pending
    wire [N-1:0] isr_nxt = (isr_r & ~({N{rd_isr}} & isr_r)) | period_end;

    always @(posedge i_clk) begin
        if (i_rst) begin
            mr_r <= 32'h00000000;
            ena_r <= {N{1'b0}};
            imr_r <= {N{1'b0}};
            isr_r <= {N{1'b0}};
        end else begin
            if (wr_mr) begin
                mr_r <= i_hwdata & 32'h0fff0fff;
            end
            if (wr_ena) begin
                ena_r <= ena_r | i_hwdata[N-1:0];
            end else if (wr_dis) begin
                ena_r <= ena_r & ~i_hwdata[N-1:0];
            end
            if (wr_ier) begin
                imr_r <= imr_r | i_hwdata[N-1:0];
            end else if (wr_idr) begin
                imr_r <= imr_r & ~i_hwdata[N-1:0];
            end
            isr_r <= isr_nxt;
        end
    end

    // level interrupt stays until the status read clears flags
    assign o_irq = |(isr_r & imr_r);

    // free-running prescaler; bit k ticks every 2^k clocks
    // all channels share it, so equal codes stay in step
    reg [PW-1:0] pre_r;
    wire [PW:0] tick_pre;

    always @(posedge i_clk) begin
        if (i_rst) begin
            pre_r <= {PW{1'b0}};
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    assign tick_pre[0] = 1'b1;
    genvar k;
    generate
        for (k = 1; k <= PW; k = k + 1) begin : g_pre
            assign tick_pre[k] = &pre_r[k-1:0];
        end
    endgenerate

    // divided clocks a and b as one-cycle enables
    wire [1:0] tick_ab;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_ab
            wire [7:0] div = mr_r[16*k+7 -: 8];
            wire [3:0] pre = mr_r[16*k+11 -: 4];
            wire src = (pre <= 4'ha) ? tick_pre[pre] : 1'b0;
            reg [7:0] dcnt_r;
            always @(posedge i_clk) begin
                if (i_rst || div == 8'h00) begin
                    dcnt_r <= 8'h00;
                end else if (src) begin
                    if (dcnt_r >= div - 8'h01) begin
                        dcnt_r <= 8'h00;
                    end else begin
                        dcnt_r <= dcnt_r + 8'h01;
                    end
                end
            end
            assign tick_ab[k] = (div != 8'h00) & src &
                                (dcnt_r >= div - 8'h01);
        end
    endgenerate

    // per-channel state, flattened for the read mux
    wire [11*N-1:0] mode_f;
    wire [CW*N-1:0] dty_f;
    wire [CW*N-1:0] prd_f;
    wire [CW*N-1:0] cnt_f;

    genvar c;
    generate
        for (c = 0; c < N; c = c + 1) begin : g_ch
            reg [10:0] mode_r;
            reg [CW-1:0] dty_r;
            reg [CW-1:0] prd_r;
            reg [CW-1:0] cnt_r;
            reg [CW-1:0] upd_r;
            reg upd_pend_r;
            reg down_r;
            reg out_r;
            reg tick;
            reg wrap;
            wire hit = wr & ch_ok & (ch_sel == c);
            wire [3:0] psc = mode_r[`PWMCRI_PSC_MSB:`PWMCRI_PSC_LSB];
            wire align = mode_r[`PWMCRI_ALIGN_BIT];
            wire pol = mode_r[`PWMCRI_POL_BIT];
            wire tgt = mode_r[`PWMCRI_TGT_BIT];
            wire start = wr_ena & i_hwdata[c];

            // counter clock select
            always @* begin
                tick = 1'b0;
                if (psc <= 4'ha) begin
                    tick = tick_pre[psc];
                end else if (psc == `PWMCRI_PSC_CLK_A) begin
                    tick = tick_ab[0];
                end else if (psc == `PWMCRI_PSC_CLK_B) begin
                    tick = tick_ab[1];
                end
            end

            // last tick of a period
            always @* begin
                wrap = 1'b0;
                if (ena_r[c] && tick) begin
                    if (prd_r == `PWMCRI_RST_16) begin
                        wrap = 1'b1;
                    end else if (!align) begin
                        wrap = (cnt_r >= prd_r - 1'b1);
                    end else begin
                        // a period of one turns at the top; its down
                        // leg is empty, so it must wrap from there
                        wrap = (cnt_r == 16'h0001) &
                               (down_r | (prd_r == 16'h0001));
                    end
                end
            end

            // counter, direction and buffered update
            always @(posedge i_clk) begin
                if (i_rst) begin
                    mode_r <= `PWMCRI_RST_MODE;
                    dty_r <= `PWMCRI_RST_16;
                    prd_r <= `PWMCRI_RST_16;
                    cnt_r <= `PWMCRI_RST_16;
                    upd_r <= `PWMCRI_RST_16;
                    upd_pend_r <= 1'b0;
                    down_r <= 1'b0;
                end else begin
                    if (hit && ch_reg == `PWMCRI_CH_REG_MODE) begin
                        mode_r <= {i_hwdata[10:8], 4'h0, i_hwdata[3:0]};
                    end
                    if (start) begin
                        cnt_r <= `PWMCRI_RST_16;
                        down_r <= 1'b0;
                    end else if (wrap) begin
                        cnt_r <= `PWMCRI_RST_16;
                        down_r <= 1'b0;
                    end else if (ena_r[c] && tick) begin
                        if (align && (down_r || cnt_r == prd_r)) begin
                            cnt_r <= cnt_r - 1'b1;
                            down_r <= 1'b1;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                    // direct writes; update at next period start
                    // an update left pending waits for a period end
                    if (wrap && upd_pend_r) begin
                        upd_pend_r <= 1'b0;
                        if (tgt) begin
                            prd_r <= upd_r;
                        end else begin
                            dty_r <= upd_r;
                        end
                    end else begin
                        if (hit && ch_reg == `PWMCRI_CH_REG_DUTY) begin
                            dty_r <= i_hwdata[CW-1:0];
                        end
                        if (hit && ch_reg == `PWMCRI_CH_REG_PRD) begin
                            prd_r <= i_hwdata[CW-1:0];
                        end
                    end
                    if (hit && ch_reg == `PWMCRI_CH_REG_UPD) begin
                        upd_r <= i_hwdata[CW-1:0];
                        upd_pend_r <= 1'b1;
                    end
                end
            end

            // waveform: start level below duty, inverse after
            always @(posedge i_clk) begin
                if (i_rst) begin
                    out_r <= 1'b0;
                end else if (!ena_r[c]) begin
                    out_r <= 1'b0;
                end else if (cnt_r < dty_r) begin
                    out_r <= pol;
                end else begin
                    out_r <= ~pol;
                end
            end

            assign o_pwm[c] = out_r;
            assign period_end[c] = wrap;
            assign mode_f[11*c +: 11] = mode_r;
            assign dty_f[CW*c +: CW] = dty_r;
            assign prd_f[CW*c +: CW] = prd_r;
            assign cnt_f[CW*c +: CW] = cnt_r;
        end
    endgenerate

    // read mux from the captured address
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h00000000;
        if (ch_ok) begin
            case (ch_reg)
                `PWMCRI_CH_REG_MODE: rd_val[10:0] = mode_f[11*ch_sel +: 11];
                `PWMCRI_CH_REG_DUTY: rd_val[CW-1:0] = dty_f[CW*ch_sel +: CW];
                `PWMCRI_CH_REG_PRD: rd_val[CW-1:0] = prd_f[CW*ch_sel +: CW];
                `PWMCRI_CH_REG_CNT: rd_val[CW-1:0] = cnt_f[CW*ch_sel +: CW];
                default: rd_val = 32'h00000000;
            endcase
        end else begin
            case (addr_r)
                `PWMCRI_OFS_MODE: rd_val = mr_r;
                `PWMCRI_OFS_STAT: rd_val[N-1:0] = ena_r;
                `PWMCRI_OFS_IMR: rd_val[N-1:0] = imr_r;
                `PWMCRI_OFS_ISR: rd_val[N-1:0] = isr_r;
                default: rd_val = 32'h00000000;
            endcase
        end
    end

    // read data register, loaded in the wait cycle
    // it only changes on a read, so it stands until the next one
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_hrdata <= 32'h00000000;
        end else begin
            if (rd_pend_r) begin
                o_hrdata <= rd_val;
            end
        end
    end

endmodule // pwmcri_top

// ===== bench/pwmcri_asserts.sv
// Purpose: bus-level checks for the pwm register interface
// Assumes: one slave, hready tied to hreadyout
// Notes: mask state and first enable tracked from bus writes
`timescale 1ns/100ps
`include "pwmcri_consts.vh"
module pwmcri_asserts #(parameter N = 4) (
    input wire i_clk, // master clock
    input wire i_rst, // sync reset
    input wire i_hsel, // select
    input wire [31:0] i_haddr, // address
    input wire [1:0] i_htrans, // transfer type
    input wire i_hwrite, // write
    input wire [2:0] i_hsize, // size
    input wire [31:0] i_hwdata, // write data
    input wire i_hready, // ready in
    input wire o_hreadyout, // ready out
    input wire o_hresp, // response
    input wire [31:0] o_hrdata, // read data
    input wire [N-1:0] o_pwm, // outputs
    input wire o_irq // interrupt
);
    reg wr_r, rd1_r, rd2_r, ena_r;
    reg [11:0] adr_r;
    reg [N-1:0] mask_r;
    wire take = i_hsel & i_hready & i_htrans[1];
    wire isr = adr_r == `PWMCRI_OFS_ISR;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // shadow of bus phases, mask and first enable; disable writes are not tracked
    always @(posedge i_clk) begin
        if (i_rst) begin
            {wr_r, rd1_r, rd2_r, ena_r, adr_r, mask_r} <= '0;
        end else begin
            wr_r <= take & i_hwrite;
            rd1_r <= take & ~i_hwrite;
            rd2_r <= rd1_r;
            if (take) begin
                adr_r <= i_haddr[11:0];
            end
            if (wr_r && adr_r == `PWMCRI_OFS_IER) begin
                mask_r <= mask_r | i_hwdata[N-1:0];
            end
            if (wr_r && adr_r == `PWMCRI_OFS_IDR) begin
                mask_r <= mask_r & ~i_hwdata[N-1:0];
            end
            if (wr_r && adr_r == `PWMCRI_OFS_ENA && |i_hwdata[N-1:0]) begin
                ena_r <= 1'b1;
            end
        end
    end
    // one wait state then data
    sequence s_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    mask_read_a: assert property (
        rd2_r && adr_r == `PWMCRI_OFS_IMR |->
        o_hrdata == {{(32-N){1'b0}}, mask_r}) else $error("mask read wrong");
    read_wait_a: assert property (
        rd1_r |-> s_wait) else $error("read wait wrong");
    write_rdy_a: assert property (
        wr_r |-> o_hreadyout) else $error("write stalled");
    idr_clear_a: assert property (
        wr_r && adr_r == `PWMCRI_OFS_IDR && &i_hwdata[N-1:0] |=> !o_irq)
        else $error("irq after full disable");
    irq_hold_a: assert property (
        o_irq && !wr_r && !(rd1_r && isr) |=> o_irq)
        else $error("irq dropped early");
    irq_mask_a: assert property (
        mask_r == '0 |-> !o_irq) else $error("irq while masked");
    isr_flag_a: assert property (
        rd2_r && isr && $past(o_irq) |-> |(o_hrdata[N-1:0] & mask_r))
        else $error("status lost flag");
    pwm_idle_a: assert property (
        !ena_r |-> o_pwm == '0) else $error("output before enable");
    resp_okay_a: assert property (
        o_hresp == 1'b0) else $error("response not okay");
endmodule // pwmcri_asserts
bind pwmcri_top pwmcri_asserts #(.N(N)) pwmcri_asserts_i (.i_clk(i_clk),
    .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_hrdata(o_hrdata), .o_pwm(o_pwm), .o_irq(o_irq));

// ===== bench/pwmcri_bench.sv
// Purpose: register and waveform tests of the pwm channel block
// Assumes: channel 0 only, master and divided clock codes
// Notes: timing measured on the output pin in clock periods
`timescale 1ns/100ps
`include "pwmcri_consts.vh"
module pwmcri_bench;
    localparam logic [11:0] C0 = 12'h200;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    wire rdy, irq;
    wire [31:0] rdata;
    wire [3:0] pwm;
    int mismatches = 0, checks_done = 0, hi, per, k;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    pwmcri_top pwmcri_top_i (.i_clk(clk), .i_rst(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(rdy),
        .o_hreadyout(rdy), .o_hresp(), .o_hrdata(rdata), .o_pwm(pwm),
        .o_irq(irq));
    // compare and count
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // one single word transfer, read data into q
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        hsize <= 3'b010;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        q = rdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, string n);
        xfer(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    // restart channel 0 with a new mode
    task automatic restart(input logic [31:0] m);
        wr(`PWMCRI_OFS_DIS, 32'h1);
        wr(C0, m);
        wr(`PWMCRI_OFS_ENA, 32'h1);
    endtask
    // high time and period of output 0
    task automatic measure;
        realtime t0, t1;
        @(posedge pwm[0]);
        t0 = $realtime;
        @(negedge pwm[0]);
        t1 = $realtime;
        @(posedge pwm[0]);
        hi = int'((t1 - t0) / 25.0);
        per = int'(($realtime - t0) / 25.0);
    endtask
    task automatic conclude;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #500000;
        mismatches++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`PWMCRI_OFS_IMR, 32'h0, "mask rst");
        rd(`PWMCRI_OFS_ISR, 32'h0, "status rst");
        wr(12'h100, 32'hffff_ffff);
        rd(12'h100, 32'h0, "unmapped");
        wr(`PWMCRI_OFS_IER, 32'hf);
        rd(`PWMCRI_OFS_IMR, 32'hf, "mask set");
        wr(`PWMCRI_OFS_IDR, 32'h5);
        rd(`PWMCRI_OFS_IMR, 32'ha, "mask part");
        wr(`PWMCRI_OFS_IDR, 32'ha);
        rd(`PWMCRI_OFS_IMR, 32'h0, "mask clr");
        wr(C0, 32'hffff_f70b);
        rd(C0, 32'h0000_070b, "mode");
        wr(C0 + 12'h4, 32'h1234_0003);
        rd(C0 + 12'h4, 32'h3, "duty");
        wr(C0 + 12'h8, 32'habcd_0008);
        rd(C0 + 12'h8, 32'h8, "period");
        // prescale codes, left aligned
        for (k = 0; k < 4; k++) begin
            restart(k);
            measure();
            chk("period", 8 << k, per);
            chk("high", 5 << k, hi);
        end
        restart(32'h200);
        measure();
        chk("high pol", 3, hi);
        restart(32'h100);
        measure();
        chk("center", 16, per);
        rd(`PWMCRI_OFS_STAT, 32'h1, "enabled");
        // divided clocks: a divides by two, b by three
        wr(`PWMCRI_OFS_MODE, 32'h0003_0002);
        rd(`PWMCRI_OFS_MODE, 32'h0003_0002, "global mode");
        restart(32'hb);
        measure();
        chk("clock a", 16, per);
        chk("clock a high", 10, hi);
        restart(32'hc);
        measure();
        chk("clock b", 24, per);
        chk("clock b high", 15, hi);
        // counter clears on enable, buffered updates
        wr(C0 + 12'h8, 32'h28);
        restart(32'h0);
        xfer(1'b0, C0 + 12'hc, 32'h0);
        chk("count", 32'h1, q);
        wr(`PWMCRI_OFS_IER, 32'h1);
        @(posedge pwm[0]);
        wr(C0 + 12'h10, 32'hffff_0005);
        rd(C0 + 12'h4, 32'h3, "duty held");
        measure();
        chk("duty upd", 35, hi);
        wr(C0, 32'h400);
        wr(C0 + 12'h10, 32'hffff_0014);
        measure();
        chk("prd upd", 20, per);
        chk("irq on", 1, irq);
        @(posedge pwm[0]);
        rd(`PWMCRI_OFS_ISR, 32'h1, "status set");
        rd(`PWMCRI_OFS_ISR, 32'h0, "status clr");
        chk("irq off", 0, irq);
        wr(`PWMCRI_OFS_IDR, 32'h1);
        measure();
        chk("irq masked", 0, irq);
        rd(`PWMCRI_OFS_ISR, 32'h1, "status masked");
        conclude();
    end
endmodule // pwmcri_bench
